//--- design/mb_link_if.sv
// byte-level link between the bus master and the register slave
`timescale 1ns/1ps
interface mb_link_if;
  logic       q_valid;
  logic [7:0] q_data;
  logic       q_last;
  logic       r_valid;
  logic [7:0] r_data;
  logic       r_last;
  logic       s_idle;

  modport slave  (input q_valid, q_data, q_last, output r_valid, r_data, r_last, s_idle);
  modport master (output q_valid, q_data, q_last, input r_valid, r_data, r_last, s_idle);
endinterface : mb_link_if

//--- design/mb_master.sv
// bus master: builds write and diagnosis queries, checks the reply
`timescale 1ns/1ps
module mb_master
  import mb_pkg::*;
#(
  parameter int TIMEOUT = RESP_TIMEOUT  // cycles to wait for a reply
)(
  input  wire logic        clk,        // system clock
  input  wire logic        rst,        // synchronous reset
  mb_link_if.master        link,       // link to the slave
  input  wire logic        cmd_valid,  // start a query
  output logic             cmd_ready_q,// idle, command accepted
  input  wire logic [7:0]  cmd_slave,  // target slave address
  input  wire logic [7:0]  cmd_func,   // 10h write or 08h diagnosis
  input  wire logic [15:0] cmd_start,  // start register address
  input  wire logic [15:0] cmd_qty,    // register quantity
  input  wire logic [7:0]  cmd_bcnt,   // byte count field
  input  wire logic [15:0] cmd_diag,   // diagnosis data word
  output logic      [6:0]  wd_idx_q,   // data word wanted
  input  wire logic [15:0] wd_data,    // data word at wd_idx_q
  output logic             done_q,     // query finished
  output logic             rsp_exc_q,  // reply was an exception
  output logic      [7:0]  rsp_code_q, // third reply byte
  output logic      [15:0] rsp_word_q, // last body word of reply
  output logic             rsp_err_q   // bad crc or timeout
);
  import mb_pkg::*;

  typedef enum logic [1:0] {M_IDLE, M_SEND, M_WAIT} mstate_t;

  mstate_t     st_q;
  logic [7:0]  slave_q;
  logic [7:0]  func_q;
  logic [31:0] w32_q;
  logic [7:0]  bcnt_q;
  logic [8:0]  b_q;
  logic        phase_q;
  logic [15:0] crc_q;
  logic [15:0] rcrc_q;
  logic [31:0] sh_q;
  logic [7:0]  rfunc_q;
  logic [3:0]  rcnt_q;
  logic [$clog2(TIMEOUT+1)-1:0] tmo_q;
  logic        q_valid_q;
  logic [7:0]  q_data_q;
  logic        q_last_q;

  logic [8:0]  body_len;
  logic [8:0]  k;
  logic [7:0]  body_byte;
  logic [15:0] rcrc_nx;

  assign body_len = (func_q == FN_DIAG) ? DIAG_BODY_LEN : WM_HDR_LEN + {1'b0, bcnt_q};
  assign k        = b_q - WM_HDR_LEN;
  assign rcrc_nx  = crc16_byte(rcrc_q, link.r_data);

  always_comb begin
    unique case (b_q)
      9'h000:  body_byte = slave_q;
      9'h001:  body_byte = func_q;
      9'h002:  body_byte = w32_q[31:24];
      9'h003:  body_byte = w32_q[23:16];
      9'h004:  body_byte = w32_q[15:8];
      9'h005:  body_byte = w32_q[7:0];
      9'h006:  body_byte = bcnt_q;
      default: body_byte = k[0] ? wd_data[7:0] : wd_data[15:8];
    endcase
  end

  // query side: one byte every second cycle so wd_data can settle
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q        <= M_IDLE;
      cmd_ready_q <= 1'b1;
      slave_q     <= 8'h00;
      func_q      <= 8'h00;
      w32_q       <= 32'h00000000;
      bcnt_q      <= 8'h00;
      b_q         <= 9'h000;
      phase_q     <= 1'b0;
      crc_q       <= CRC_INIT;
      wd_idx_q    <= 7'h00;
      q_valid_q   <= 1'b0;
      q_data_q    <= 8'h00;
      q_last_q    <= 1'b0;
    end else begin
      q_valid_q <= 1'b0;
      q_last_q  <= 1'b0;
      unique case (st_q)
        M_IDLE: begin
          if (cmd_valid && link.s_idle) begin
            cmd_ready_q <= 1'b0;
            slave_q     <= cmd_slave;
            func_q      <= cmd_func;
            w32_q       <= (cmd_func == FN_DIAG) ? {DIAG_SUB_ECHO, cmd_diag}
                                                 : {cmd_start, cmd_qty};
            bcnt_q      <= cmd_bcnt;
            b_q         <= 9'h000;
            phase_q     <= 1'b0;
            crc_q       <= CRC_INIT;
            st_q        <= M_SEND;
          end
        end
        M_SEND: begin
          phase_q <= ~phase_q;
          if (!phase_q) begin
            wd_idx_q <= k[7:1];
          end else begin
            q_valid_q <= 1'b1;
            b_q       <= b_q + 9'h001;
            if (b_q < body_len) begin
              q_data_q <= body_byte;
              crc_q    <= crc16_byte(crc_q, body_byte);
            end else if (b_q == body_len) begin
              q_data_q <= crc_q[7:0];
            end else begin
              q_data_q <= crc_q[15:8];
              q_last_q <= 1'b1;
              st_q     <= M_WAIT;
            end
          end
        end
        M_WAIT: begin
          if (done_q) begin
            st_q        <= M_IDLE;
            cmd_ready_q <= 1'b1;
          end
        end
        default: st_q <= M_IDLE;
      endcase
    end
  end

  // reply side: crc check and capture of the answer fields
  always_ff @(posedge clk) begin
    if (rst || st_q != M_WAIT) begin
      rcrc_q     <= CRC_INIT;
      sh_q       <= 32'h00000000;
      rfunc_q    <= 8'h00;
      rcnt_q     <= 4'h0;
      tmo_q      <= '0;
      done_q     <= 1'b0;
      rsp_exc_q  <= rst ? 1'b0 : rsp_exc_q;
      rsp_code_q <= rst ? 8'h00 : rsp_code_q;
      rsp_word_q <= rst ? 16'h0000 : rsp_word_q;
      rsp_err_q  <= rst ? 1'b0 : rsp_err_q;
    end else if (!done_q) begin
      tmo_q <= tmo_q + 1'b1;
      // broadcast gets no reply
      if (slave_q == BCAST_ADDR) begin
        done_q    <= 1'b1;
        rsp_exc_q <= 1'b0;
        rsp_err_q <= 1'b0;
      end else if (link.r_valid) begin
        rcrc_q <= rcrc_nx;
        sh_q   <= {sh_q[23:0], link.r_data};
        if (rcnt_q != 4'hF) begin
          rcnt_q <= rcnt_q + 4'h1;
        end
        if (rcnt_q == 4'h1) begin
          rfunc_q <= link.r_data;
        end
        if (rcnt_q == 4'h2) begin
          rsp_code_q <= link.r_data;
        end
        if (link.r_last) begin
          done_q     <= 1'b1;
          rsp_exc_q  <= rfunc_q[7];
          rsp_word_q <= sh_q[23:8];
          rsp_err_q  <= (rcrc_nx != CRC_RESIDUE);
        end
      end else if (tmo_q == ($clog2(TIMEOUT+1))'(TIMEOUT)) begin
        done_q    <= 1'b1;
        rsp_err_q <= 1'b1;
      end
    end
  end

  assign link.q_valid = q_valid_q;
  assign link.q_data  = q_data_q;
  assign link.q_last  = q_last_q;
endmodule : mb_master

//--- design/mb_pkg.sv
// shared constants, register map and crc helper for the register-write link
package mb_pkg;
  localparam logic [7:0]  FN_WRITE_MULTI = 8'h10;
  localparam logic [7:0]  FN_DIAG        = 8'h08;
  localparam logic [15:0] DIAG_SUB_ECHO  = 16'h0000;
  localparam logic [7:0]  EXC_FLAG       = 8'h80;
  localparam logic [7:0]  EXC_ILL_FUNC   = 8'h01;
  localparam logic [7:0]  EXC_ILL_ADDR   = 8'h02;
  localparam logic [7:0]  EXC_ILL_DATA   = 8'h03;
  localparam logic [7:0]  EXC_NONE       = 8'h00;
  localparam logic [7:0]  BCAST_ADDR     = 8'h00;

  localparam int          MAX_REGS       = 123;
  localparam int          HDR_LEN        = 8;
  localparam logic [8:0]  WM_HDR_LEN     = 9'h007;
  localparam logic [8:0]  DIAG_LEN       = 9'h008;
  localparam logic [8:0]  DIAG_BODY_LEN  = 9'h006;
  localparam logic [8:0]  MIN_FRAME_LEN  = 9'h008;
  localparam logic [2:0]  ECHO_RESP_LEN  = 3'h6;
  localparam logic [2:0]  EXC_RESP_LEN   = 3'h3;

  // holding registers: each 32-bit setting is upper half then lower half
  localparam int          NUM_REGS       = 6;
  localparam logic [15:0] REG_BASE       = 16'h18C6;
  localparam logic [15:0] REG_START_RATE_HIGH  = 16'h18C6;
  localparam logic [15:0] REG_START_RATE_LOW   = 16'h18C7;
  localparam logic [15:0] REG_STOP_DECEL_HIGH  = 16'h18C8;
  localparam logic [15:0] REG_STOP_DECEL_LOW   = 16'h18C9;
  localparam logic [15:0] REG_DRIVE_CURR_HIGH  = 16'h18CA;
  localparam logic [15:0] REG_DRIVE_CURR_LOW   = 16'h18CB;
  localparam logic [15:0] REG_RESET_VAL  = 16'h0000;
  localparam logic [15:0] PARAM_HI_MAX   = 16'h0FFF;

  localparam logic [15:0] CRC_INIT       = 16'hFFFF;
  localparam logic [15:0] CRC_POLY       = 16'hA001;
  localparam logic [15:0] CRC_RESIDUE    = 16'h0000;

  localparam int          RESP_TIMEOUT   = 200000;

  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc16_byte
endpackage : mb_pkg

//--- design/mb_slave.sv
// register slave: multi-register write and diagnosis echo
// Operation
// - accept 10h, up to 123 registers
// - master writes both halves together; the slave does not check this and commits a single half on its own
// - commit values in ascending address order
// - invalid value gives exception, earlier writes stay
// - master sends address, 10h, start address
// - master sends register quantity, high first
// - byte count equals twice quantity
// - data one word per register, high first
// - frames end with crc, low byte first
// - normal reply echoes header plus new crc
// - upper half low address, lower next
// - diagnosis 08h/00h echoes query frame
`timescale 1ns/1ps
module mb_slave
  import mb_pkg::*;
(
  input  wire logic        clk,        // system clock
  input  wire logic        rst,        // synchronous reset
  mb_link_if.slave         link,       // link to the master
  input  wire logic [7:0]  my_addr,    // own slave address
  input  wire logic [2:0]  rd_idx,     // register file read index
  output logic      [15:0] rd_data_q,  // register value at rd_idx
  output logic             wr_pulse_q, // one register committed
  output logic      [15:0] wr_addr_q,  // address of committed register
  output logic      [15:0] wr_data_q,  // value committed
  output logic      [7:0]  exc_q,      // last exception code sent
  output logic             crc_err_q   // frame dropped on crc error
);
  import mb_pkg::*;

  typedef enum logic [1:0] {RX, DECIDE, COMMIT, SEND} state_t;

  state_t      st_q;
  logic [7:0]  hdr_q [HDR_LEN];
  logic [15:0] buf_q [MAX_REGS];
  logic [15:0] regs_q [NUM_REGS];
  logic [8:0]  len_q;
  logic [15:0] crc_q;
  logic [6:0]  idx_q;
  logic        bcast_q;
  logic [7:0]  code_q;
  logic [2:0]  tx_idx_q;
  logic [15:0] tx_crc_q;
  logic        r_valid_q;
  logic [7:0]  r_data_q;
  logic        r_last_q;

  logic [15:0] start_w;
  logic [15:0] qty_w;
  logic [8:0]  data_pos;
  logic [15:0] cur_addr;
  logic [15:0] rel_addr;
  logic        in_map;
  logic [15:0] cur_val;
  logic [2:0]  resp_len;
  logic [7:0]  body_byte;
  logic        tx_done;
  logic        qty_bad;

  assign start_w  = {hdr_q[2], hdr_q[3]};
  assign qty_w    = {hdr_q[4], hdr_q[5]};
  assign data_pos = len_q - WM_HDR_LEN;
  assign cur_addr = start_w + {9'h000, idx_q};
  assign rel_addr = cur_addr - REG_BASE;
  assign in_map   = (cur_addr >= REG_BASE) && (rel_addr < 16'(NUM_REGS));
  assign cur_val  = buf_q[idx_q];
  assign resp_len = (code_q != EXC_NONE) ? EXC_RESP_LEN : ECHO_RESP_LEN;
  assign tx_done  = (st_q == SEND) && (tx_idx_q == resp_len + 3'h1);
  // quantity window and byte count must agree before anything is written
  assign qty_bad  = (qty_w == 16'h0000) || (qty_w > 16'(MAX_REGS))
                    || ({8'h00, hdr_q[6]} != {qty_w[14:0], 1'b0})
                    || (len_q != WM_HDR_LEN + {1'b0, hdr_q[6]} + 9'h002);

  always_comb begin
    body_byte = hdr_q[tx_idx_q];
    if (code_q != EXC_NONE) begin
      unique case (tx_idx_q)
        3'h0:    body_byte = hdr_q[0];
        3'h1:    body_byte = hdr_q[1] | EXC_FLAG;
        default: body_byte = code_q;
      endcase
    end
  end

  // receive: header capture, data buffering, running crc
  always_ff @(posedge clk) begin
    if (rst || st_q == DECIDE) begin
      len_q <= 9'h000;
      crc_q <= CRC_INIT;
    end else if (st_q == RX && link.q_valid) begin
      crc_q <= crc16_byte(crc_q, link.q_data);
      if (len_q != 9'h1FF) begin
        len_q <= len_q + 9'h001;
      end
      if (len_q < 9'(HDR_LEN)) begin
        hdr_q[len_q[2:0]] <= link.q_data;
      end
      // data words arrive high byte first, one per register
      if (len_q >= WM_HDR_LEN && data_pos[8:1] < 8'(MAX_REGS)) begin
        if (!data_pos[0]) begin
          buf_q[data_pos[7:1]][15:8] <= link.q_data;
        end else begin
          buf_q[data_pos[7:1]][7:0] <= link.q_data;
        end
      end
    end
  end

  // control sequence
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q      <= RX;
      idx_q     <= 7'h00;
      bcast_q   <= 1'b0;
      code_q    <= EXC_NONE;
      exc_q     <= EXC_NONE;
      crc_err_q <= 1'b0;
    end else begin
      crc_err_q <= 1'b0;
      unique case (st_q)
        RX: begin
          if (link.q_valid && link.q_last) begin
            st_q <= DECIDE;
          end
        end
        DECIDE: begin
          idx_q   <= 7'h00;
          code_q  <= EXC_NONE;
          bcast_q <= (hdr_q[0] == BCAST_ADDR);
          st_q    <= RX;
          if (len_q < MIN_FRAME_LEN) begin
            st_q <= RX;
          end else if (crc_q != CRC_RESIDUE) begin
            crc_err_q <= 1'b1;
          end else if (hdr_q[0] == my_addr || hdr_q[0] == BCAST_ADDR) begin
            // broadcast frames are acted on but never answered
            if (hdr_q[1] == FN_WRITE_MULTI) begin
              if (qty_bad) begin
                code_q <= EXC_ILL_DATA;
                st_q   <= (hdr_q[0] == BCAST_ADDR) ? RX : SEND;
              end else begin
                st_q <= COMMIT;
              end
            end else if (hdr_q[1] == FN_DIAG) begin
              if ({hdr_q[2], hdr_q[3]} != DIAG_SUB_ECHO) begin
                code_q <= EXC_ILL_FUNC;
              end else if (len_q != DIAG_LEN) begin
                code_q <= EXC_ILL_DATA;
              end
              st_q <= (hdr_q[0] == BCAST_ADDR) ? RX : SEND;
            end else begin
              code_q <= EXC_ILL_FUNC;
              st_q   <= (hdr_q[0] == BCAST_ADDR) ? RX : SEND;
            end
          end
        end
        COMMIT: begin
          // stop at the first bad register; earlier ones are kept
          if (!in_map) begin
            code_q <= EXC_ILL_ADDR;
            st_q   <= bcast_q ? RX : SEND;
          end else if (!rel_addr[0] && cur_val > PARAM_HI_MAX) begin
            code_q <= EXC_ILL_DATA;
            st_q   <= bcast_q ? RX : SEND;
          end else if ({9'h000, idx_q} == qty_w - 16'h0001) begin
            st_q <= bcast_q ? RX : SEND;
          end else begin
            idx_q <= idx_q + 7'h01;
          end
        end
        SEND: begin
          if (tx_done) begin
            exc_q <= code_q;
            st_q  <= RX;
          end
        end
      endcase
    end
  end

  // register file, written one word per cycle in address order
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= REG_RESET_VAL;
      end
      wr_pulse_q <= 1'b0;
      wr_addr_q  <= 16'h0000;
      wr_data_q  <= 16'h0000;
      rd_data_q  <= REG_RESET_VAL;
    end else begin
      wr_pulse_q <= 1'b0;
      rd_data_q  <= (rd_idx < 3'(NUM_REGS)) ? regs_q[rd_idx] : 16'h0000;
      if (st_q == COMMIT && in_map && !(!rel_addr[0] && cur_val > PARAM_HI_MAX)) begin
        regs_q[rel_addr[2:0]] <= cur_val;
        wr_pulse_q <= 1'b1;
        wr_addr_q  <= cur_addr;
        wr_data_q  <= cur_val;
      end
    end
  end

  // transmit: body bytes, then fresh crc low then high
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_idx_q  <= 3'h0;
      tx_crc_q  <= CRC_INIT;
      r_valid_q <= 1'b0;
      r_data_q  <= 8'h00;
      r_last_q  <= 1'b0;
    end else begin
      r_valid_q <= 1'b0;
      r_last_q  <= 1'b0;
      if (st_q == SEND) begin
        r_valid_q <= 1'b1;
        if (tx_idx_q < resp_len) begin
          r_data_q <= body_byte;
          tx_crc_q <= crc16_byte(tx_crc_q, body_byte);
        end else if (tx_idx_q == resp_len) begin
          r_data_q <= tx_crc_q[7:0];
        end else begin
          r_data_q <= tx_crc_q[15:8];
          r_last_q <= 1'b1;
        end
        tx_idx_q <= tx_done ? 3'h0 : tx_idx_q + 3'h1;
        if (tx_done) begin
          tx_crc_q <= CRC_INIT;
        end
      end
    end
  end

  assign link.r_valid = r_valid_q;
  assign link.r_data  = r_data_q;
  assign link.r_last  = r_last_q;
  assign link.s_idle  = (st_q == RX);
endmodule : mb_slave

//--- dv/mb_dv_pkg.sv
// crc reference shared by the checker and the bench
package mb_dv_pkg;
  function automatic logic [15:0] crc_next(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] x;
    x = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ 16'hA001) : (x >> 1);
    end
    return x;
  endfunction : crc_next
endpackage : mb_dv_pkg

//--- dv/mb_link_properties.sv
// concurrent checks on the link between the two ends
`timescale 1ns/1ps
module mb_link_checker
  import mb_pkg::*;
  import mb_dv_pkg::*;
#(
  parameter logic [7:0] OWN_ADDR = 8'h04  // address of the slave under watch
)(
  input wire logic       clk,     // system clock
  input wire logic       rst,     // synchronous reset
  input wire logic       q_valid, // query byte valid
  input wire logic [7:0] q_data,  // query byte
  input wire logic       q_last,  // last query byte
  input wire logic       r_valid, // reply byte valid
  input wire logic [7:0] r_data,  // reply byte
  input wire logic       r_last,  // last reply byte
  input wire logic       s_idle   // slave waits for a query
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0]  qb_q [0:5];
  logic [8:0]  qcnt_q;
  logic [15:0] qcrc_q;
  logic [7:0]  rcnt_q;
  logic [15:0] rcrc_q;
  logic        rexc_q;
  logic        q_take;
  // bytes offered while busy are ignored by the slave, so not counted here
  assign q_take = q_valid && s_idle;
  always_ff @(posedge clk) begin
    if (rst || (q_take && q_last)) begin
      qcnt_q <= 9'h000;
      qcrc_q <= 16'hFFFF;
    end else if (q_take) begin
      // wide enough for a full 255-byte frame, so the capture never wraps
      qcnt_q <= qcnt_q + 9'h001;
      qcrc_q <= crc_next(qcrc_q, q_data);
    end
  end
  always_ff @(posedge clk) begin
    if (q_take && qcnt_q < 9'h006) begin
      qb_q[qcnt_q[2:0]] <= q_data;
    end
  end
  always_ff @(posedge clk) begin
    if (rst || (r_valid && r_last)) begin
      rcnt_q <= 8'h00;
      rcrc_q <= 16'hFFFF;
    end else if (r_valid) begin
      rcnt_q <= rcnt_q + 8'h01;
      rcrc_q <= crc_next(rcrc_q, r_data);
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      rexc_q <= 1'b0;
    end else if (r_valid && rcnt_q == 8'h01) begin
      rexc_q <= r_data[7];
    end
  end
  property p_query_crc;
    q_take && q_last |-> crc_next(qcrc_q, q_data) == 16'h0000;
  endproperty
  a_query_crc: assert property (p_query_crc) else $error("query crc wrong");
  property p_reply_crc;
    r_valid && r_last |-> crc_next(rcrc_q, r_data) == 16'h0000;
  endproperty
  a_reply_crc: assert property (p_reply_crc) else $error("reply crc wrong");
  property p_reply_len;
    r_valid && r_last |-> (rexc_q ? rcnt_q == 8'h04 : rcnt_q == 8'h07);
  endproperty
  a_reply_len: assert property (p_reply_len) else $error("reply length wrong");
  property p_echo_addr;
    r_valid && rcnt_q == 8'h00 |-> r_data == qb_q[0];
  endproperty
  a_echo_addr: assert property (p_echo_addr) else $error("reply address wrong");
  property p_exc_func;
    r_valid && rcnt_q == 8'h01 && r_data[7] |-> r_data == (qb_q[1] | EXC_FLAG);
  endproperty
  a_exc_func: assert property (p_exc_func) else $error("exception function wrong");
  property p_echo_body;
    r_valid && rcnt_q >= 8'h01 && rcnt_q <= 8'h05 && !(rcnt_q == 8'h01 ? r_data[7] : rexc_q)
      |-> r_data == qb_q[rcnt_q[2:0]];
  endproperty
  a_echo_body: assert property (p_echo_body) else $error("echo byte wrong");
  property p_reply_soon;
    q_take && q_last && qb_q[0] == OWN_ADDR && crc_next(qcrc_q, q_data) == 16'h0000
      |=> !r_valid ##[1:125] r_valid;
  endproperty
  a_reply_soon: assert property (p_reply_soon) else $error("reply late or early");
  property p_reply_run;
    // slave is back in receive while its final byte is still on the link
    r_valid && !r_last |=> r_valid && (r_last || !s_idle);
  endproperty
  a_reply_run: assert property (p_reply_run) else $error("reply not contiguous");
  property p_idle_after;
    r_valid && r_last |=> s_idle && !r_valid;
  endproperty
  a_idle_after: assert property (p_idle_after) else $error("no idle after reply");
endmodule : mb_link_checker

//--- dv/tb.sv
// self-checking bench: master and slave joined, plus a slave fed a bad frame
`timescale 1ns/1ps
module tb;
  import mb_pkg::*;
  import mb_dv_pkg::*;
  localparam logic [7:0]  MY_ADDR = 8'h04;
  localparam logic [15:0] EX [0:5] = '{16'h0000, 16'h2710, 16'h0000, 16'h4E20, 16'h0000,
                                       16'h01F4};
  localparam logic [39:0] CASES [0:5] = '{{16'h18C6, 16'h0000, 8'h00},
    {16'h18C6, 16'h007C, 8'hF8}, {16'h18C6, 16'h0002, 8'h03}, {16'h18C8, 16'h0002, 8'h04},
    {16'h18C6, 16'h007B, 8'hF6}, {16'h18C4, 16'h0002, 8'h04}};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cmd_valid = 1'b0;
  logic        cmd_ready_q, done_q, rsp_exc_q, rsp_err_q, wr_pulse_q, crc_err_q, b_crc_err, b_wr;
  logic [7:0]  cmd_slave = MY_ADDR;
  logic [7:0]  cmd_func = 8'h00;
  logic [15:0] cmd_start = 16'h0000;
  logic [15:0] cmd_qty = 16'h0000;
  logic [7:0]  cmd_bcnt = 8'h00;
  logic [15:0] cmd_diag = 16'h0000;
  logic [2:0]  rd_idx = 3'h0;
  logic [6:0]  wd_idx_q;
  logic [15:0] wd_data, rsp_word_q, rd_data_q, wr_addr_q, wr_data_q;
  logic [7:0]  rsp_code_q, exc_q;
  logic [15:0] words [0:127];
  logic [15:0] regs_m [0:7];
  logic [31:0] commits [$];
  logic [7:0]  qbytes [$];
  int          fails, tests_run, cycles, b_events, b_crc_cnt;
  mb_link_if link();
  mb_link_if link_b();
  assign wd_data = words[wd_idx_q];
  always #2.5 clk = ~clk;
  mb_master #(.TIMEOUT(200)) u_mb_master (.clk(clk), .rst(rst), .link(link),
    .cmd_valid(cmd_valid), .cmd_ready_q(cmd_ready_q), .cmd_slave(cmd_slave),
    .cmd_func(cmd_func), .cmd_start(cmd_start), .cmd_qty(cmd_qty), .cmd_bcnt(cmd_bcnt),
    .cmd_diag(cmd_diag), .wd_idx_q(wd_idx_q), .wd_data(wd_data), .done_q(done_q),
    .rsp_exc_q(rsp_exc_q), .rsp_code_q(rsp_code_q), .rsp_word_q(rsp_word_q),
    .rsp_err_q(rsp_err_q));
  mb_slave u_mb_slave (.clk(clk), .rst(rst), .link(link), .my_addr(MY_ADDR), .rd_idx(rd_idx),
    .rd_data_q(rd_data_q), .wr_pulse_q(wr_pulse_q), .wr_addr_q(wr_addr_q),
    .wr_data_q(wr_data_q), .exc_q(exc_q), .crc_err_q(crc_err_q));
  mb_slave u_mb_slave_b (.clk(clk), .rst(rst), .link(link_b), .my_addr(MY_ADDR),
    .rd_idx(rd_idx), .rd_data_q(), .wr_pulse_q(b_wr), .wr_addr_q(), .wr_data_q(), .exc_q(),
    .crc_err_q(b_crc_err));
  mb_link_checker #(.OWN_ADDR(MY_ADDR)) u_chk (.clk(clk), .rst(rst), .q_valid(link.q_valid),
    .q_data(link.q_data), .q_last(link.q_last), .r_valid(link.r_valid), .r_data(link.r_data),
    .r_last(link.r_last), .s_idle(link.s_idle));

  task automatic wrap_up();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // monitors sample before the edge updates, so each value is the settled one
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (wr_pulse_q === 1'b1) commits.push_back({wr_addr_q, wr_data_q});
    if (link.q_valid === 1'b1 && link.s_idle === 1'b1) qbytes.push_back(link.q_data);
    if (link_b.r_valid === 1'b1 || b_wr === 1'b1) b_events++;
    if (b_crc_err === 1'b1) b_crc_cnt++;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic run(input logic [7:0] fn, input logic [15:0] st, input logic [15:0] qty,
                     input logic [7:0] bc, input logic [15:0] dg);
    int n;
    n = 0;
    commits.delete();
    qbytes.delete();
    @(posedge clk);
    cmd_func  <= fn;
    cmd_start <= st;
    cmd_qty   <= qty;
    cmd_bcnt  <= bc;
    cmd_diag  <= dg;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    while (done_q !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 3000) fails++;
    chk({15'h0000, rsp_err_q}, 16'h0000);
  endtask : run

  task automatic rdchk(input int idx);
    @(posedge clk);
    rd_idx <= 3'(idx);
    @(posedge clk);
    #1;
    chk(rd_data_q, regs_m[idx]);
  endtask : rdchk

  // predicts outcome and register state, then runs one block write
  task automatic wr(input logic [15:0] st, input logic [15:0] qty, input logic [7:0] bc);
    logic [7:0]  code;
    logic [15:0] a;
    logic [31:0] expq [$];
    code = EXC_NONE;
    if (qty == 16'h0000 || qty > 16'(MAX_REGS) || {8'h00, bc} != {qty[14:0], 1'b0}) begin
      code = EXC_ILL_DATA;
    end
    for (int i = 0; i < int'(qty) && code == EXC_NONE; i++) begin
      a = st + 16'(i);
      if (a < REG_BASE || a > REG_DRIVE_CURR_LOW) begin
        code = EXC_ILL_ADDR;
      end else if (a[0] == 1'b0 && words[i] > PARAM_HI_MAX) begin
        code = EXC_ILL_DATA;
      end else begin
        expq.push_back({a, words[i]});
        regs_m[a - REG_BASE] = words[i];
      end
    end
    run(FN_WRITE_MULTI, st, qty, bc, 16'h0000);
    chk({15'h0000, rsp_exc_q}, {15'h0000, code != EXC_NONE});
    chk({8'h00, exc_q}, {8'h00, code});
    chk({8'h00, rsp_code_q}, {8'h00, code == EXC_NONE ? st[15:8] : code});
    if (code == EXC_NONE) chk(rsp_word_q, qty);
    chk(16'(commits.size()), 16'(expq.size()));
    for (int i = 0; i < expq.size() && i < commits.size(); i++) begin
      chk(commits[i][31:16], expq[i][31:16]);
      chk(commits[i][15:0], expq[i][15:0]);
    end
    for (int i = 0; i < 8; i++) rdchk(i);
  endtask : wr

  // second slave only: a frame whose high check byte is broken on purpose
  task automatic send_bad();
    logic [7:0]  f [$];
    logic [15:0] c;
    f = '{MY_ADDR, FN_WRITE_MULTI, 8'h18, 8'hC6, 8'h00, 8'h01, 8'h02, 8'h00, 8'h05};
    c = 16'hFFFF;
    foreach (f[i]) c = crc_next(c, f[i]);
    f.push_back(c[7:0]);
    f.push_back(c[15:8] ^ 8'h01);
    foreach (f[i]) begin
      @(posedge clk);
      link_b.q_valid <= 1'b1;
      link_b.q_data  <= f[i];
      link_b.q_last  <= (i == f.size() - 1);
      @(posedge clk);
      link_b.q_valid <= 1'b0;
      link_b.q_last  <= 1'b0;
      link_b.q_data  <= ~f[i];
    end
    repeat (30) @(posedge clk);
    #1;
    chk(16'(b_crc_cnt), 16'h0001);
    chk(16'(b_events), 16'h0000);
  endtask : send_bad

  initial begin
    logic [7:0]  hdr [0:6];
    logic [15:0] c;
    link_b.q_valid = 1'b0;
    link_b.q_data  = 8'h00;
    link_b.q_last  = 1'b0;
    for (int i = 0; i < 128; i++) words[i] = 16'(i) ^ 16'h0A50;
    for (int i = 0; i < 8; i++) regs_m[i] = REG_RESET_VAL;
    for (int i = 0; i < 6; i++) words[i] = EX[i];
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    wr(REG_BASE, 16'h0006, 8'h0C);
    hdr = '{MY_ADDR, FN_WRITE_MULTI, 8'h18, 8'hC6, 8'h00, 8'h06, 8'h0C};
    chk(16'(qbytes.size()), 16'h0015);
    for (int i = 0; i < 7; i++) chk({8'h00, qbytes[i]}, {8'h00, hdr[i]});
    for (int i = 0; i < 12; i++) begin
      chk({8'h00, qbytes[7 + i]}, {8'h00, i[0] ? EX[i / 2][7:0] : EX[i / 2][15:8]});
    end
    c = 16'hFFFF;
    foreach (qbytes[i]) c = crc_next(c, qbytes[i]);
    chk(c, 16'h0000);
    words[0] = 16'h0123;
    words[1] = 16'h4567;
    words[2] = 16'h1000;
    wr(REG_BASE, 16'h0006, 8'h0C);
    words[2] = 16'h0ABC;
    for (int k = 0; k < 6; k++) wr(CASES[k][39:24], CASES[k][23:8], CASES[k][7:0]);
    run(FN_DIAG, DIAG_SUB_ECHO, 16'h0000, 8'h00, 16'h1234);
    chk({15'h0000, rsp_exc_q}, 16'h0000);
    chk(rsp_word_q, 16'h1234);
    chk(16'(qbytes.size()), 16'h0008);
    chk(16'(commits.size()), 16'h0000);
    send_bad();
    wrap_up();
  end
endmodule : tb
